// ===== adc_readout_pkg.sv
package adc_readout_pkg;
   // Width of one conversion result
   localparam int RESULT_W = 16;
   // Rising serial clock edge, counted within a frame, that releases the output
   localparam int HIZ_EDGE = 17;
   // Width of the frame edge counter
   localparam int EDGE_CNT_W = 5;
   // Reset value of the held result
   localparam logic [RESULT_W-1:0] RESULT_RST = 16'h0000;
   // Reset value of the edge counter
   localparam logic [EDGE_CNT_W-1:0] EDGE_CNT_RST = 5'h00;
   // Idle level of the synchronised chip select
   localparam logic CS_IDLE = 1'b1;
endpackage : adc_readout_pkg

// ===== adc_serial_result_readout.sv
// Contract
// (R1) Falling chip select releases the result output from high impedance promptly.
// (R2) A DSP host may drive chip select from its frame-sync output.
// (R3) While chip select is high the result output stays high impedance.
// (R4) After chip select falls, bits are driven until the LSB is presented.
// (R5) The result shifts out MSB first, LSB last.
// (R6) After the first bit, each serial clock rising edge presents the next bit.
// (R7) Each bit is stable at serial clock falling edges; host samples there.
// (R8) Output returns to high impedance after the seventeenth rising edge in a frame.
// (R9) Without a seventeenth edge, chip select rising returns output to high impedance.
// (R10) Each frame carries a sixteen-bit result; the LSB is the sixteenth bit.
// (R11) Each frame starts on a fresh chip select fall; bit position restarts at MSB.
module adc_serial_result_readout #(
   parameter int RESULT_W = adc_readout_pkg::RESULT_W,
   parameter int HIZ_EDGE = adc_readout_pkg::HIZ_EDGE
) (
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic [RESULT_W-1:0] result_in,
   input wire logic result_valid_in,
   output logic result_ready_out,
   output logic frame_active_out,
   input wire logic sclk_in,
   input wire logic cs_n_in,
   output logic serial_result_out,
   output logic serial_result_oe_out
);
   localparam int CW = adc_readout_pkg::EDGE_CNT_W;

   // Parameter checks refuse sizes the counter and reset value cannot serve
   if (RESULT_W < 2) begin : g_bad_width
      $error("adc_serial_result_readout: RESULT_W must be at least 2");
   end

   if (RESULT_W > $bits(adc_readout_pkg::RESULT_RST)) begin : g_wide_width
      $error("adc_serial_result_readout: RESULT_W wider than the reset value");
   end

   if (HIZ_EDGE <= RESULT_W) begin : g_early_hiz
      $error("adc_serial_result_readout: HIZ_EDGE must follow the last bit");
   end

   if (HIZ_EDGE >= (1 << CW)) begin : g_wide_hiz
      $error("adc_serial_result_readout: HIZ_EDGE does not fit the edge counter");
   end

   localparam logic [CW-1:0] HIZ_CNT = CW'(HIZ_EDGE);
   localparam logic [CW-1:0] LAST_CNT = CW'(RESULT_W);
   localparam logic [CW-1:0] ONE_CNT = CW'(1);

   // Link states: shifting result bits, driving the tail, released
   typedef enum logic [1:0] {
      LINK_SHIFT = 2'b00,
      LINK_TAIL = 2'b01,
      LINK_DONE = 2'b10
   } link_state_e;

   // System domain: chip select seen through two flops
   logic cs_n_sync;

   level_sync #(
      .WIDTH(1),
      .RST_VAL(adc_readout_pkg::CS_IDLE)
   ) u_cs_sync (
      .clk_in(clk_sys_in),
      .rst_in(rst_in),
      .async_in(cs_n_in),
      .sync_out(cs_n_sync)
   );

   // Frame flag as seen by the system side
   logic frame_active;

   always_comb begin
      frame_active = ~cs_n_sync;
   end

   assign frame_active_out = frame_active;

   // Ready trails the frame flag by one cycle; the take also needs synchronised chip select high, so the word cannot change once the frame flag is set
   logic ready_r;
   logic ready_nxt;

   always_comb begin
      ready_nxt = ~frame_active;
   end

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         ready_r <= 1'b0;
      end else begin
         ready_r <= ready_nxt;
      end
   end

   assign result_ready_out = ready_r;

   // Result word held steady for the link while a frame is open
   logic [RESULT_W-1:0] hold_r;
   logic [RESULT_W-1:0] hold_nxt;
   logic take_word;

   always_comb begin
      take_word = result_valid_in && ready_r && cs_n_sync;
      hold_nxt = hold_r;
      if (take_word) begin
         hold_nxt = result_in;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         hold_r <= adc_readout_pkg::RESULT_RST[RESULT_W-1:0];
      end else begin
         hold_r <= hold_nxt;
      end
   end

   // Link domain: rising serial clock edges counted within a frame
   logic [CW-1:0] edge_cnt_r;
   logic [CW-1:0] edge_cnt_nxt;

   always_comb begin
      edge_cnt_nxt = edge_cnt_r;
      if (edge_cnt_r != HIZ_CNT) begin
         edge_cnt_nxt = edge_cnt_r + ONE_CNT; // (R6)
      end
   end

   // Chip select high clears the counter, so every frame restarts at the MSB
   always_ff @(posedge sclk_in or posedge cs_n_in) begin
      if (cs_n_in) begin
         edge_cnt_r <= adc_readout_pkg::EDGE_CNT_RST; // (R11)
      end else begin
         edge_cnt_r <= edge_cnt_nxt;
      end
   end

   // Link state follows the counter and decides what the pin shows
   link_state_e link_state_r;
   link_state_e link_state_nxt;

   always_comb begin
      link_state_nxt = link_state_r;
      case (link_state_r)
         LINK_SHIFT: begin
            if (edge_cnt_nxt == LAST_CNT) begin
               link_state_nxt = LINK_TAIL; // (R10)
            end
         end
         LINK_TAIL: begin
            if (edge_cnt_nxt == HIZ_CNT) begin
               link_state_nxt = LINK_DONE; // (R8)
            end
         end
         LINK_DONE: begin
            link_state_nxt = LINK_DONE;
         end
         default: begin
            link_state_nxt = LINK_SHIFT;
         end
      endcase
   end

   // Chip select high returns the link to the first bit of a new frame
   always_ff @(posedge sclk_in or posedge cs_n_in) begin
      if (cs_n_in) begin
         link_state_r <= LINK_SHIFT; // (R11)
      end else begin
         link_state_r <= link_state_nxt;
      end
   end

   // Bit selection: position 0 is the MSB, position RESULT_W-1 the LSB
   logic [CW-1:0] bit_pos;
   logic shifting;
   logic bit_sel;

   always_comb begin
      bit_pos = edge_cnt_r;
      shifting = (link_state_r == LINK_SHIFT);
      bit_sel = 1'b0;
      if (shifting) begin
         if (bit_pos < LAST_CNT) begin
            bit_sel = hold_r[RESULT_W - 1 - int'(bit_pos)]; // (R5) (R10) (R7)
         end
      end
   end

   // Pin is driven inside a frame until the closing edge
   logic drive_en;

   always_comb begin
      drive_en = 1'b0;
      if (!cs_n_in) begin
         if (link_state_r != LINK_DONE) begin
            drive_en = 1'b1; // (R1) (R4)
         end
      end
   end

   assign serial_result_out = bit_sel; // (R4)
   // Released while chip select is high or after the closing edge
   assign serial_result_oe_out = drive_en; // (R1) (R3) (R8) (R9)
endmodule : adc_serial_result_readout

// ===== host_port.sv
module host_port (
   output logic sclk_out,
   output logic cs_n_out,
   input wire logic sdo_in,
   input wire logic oe_in
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      sclk_out = 1'b0;
      cs_n_out = 1'b1;
   end
   // Frame of n clocks; sclk stands still between frames
   task automatic frame(input int n, output logic [15:0] got, output logic oe);
      cs_n_out = 1'b0;
      for (int i = 0; i < n; i++) begin
         #7.5 if (i < 16) got = {got[14:0], sdo_in};
         sclk_out = 1'b1;
         #7.5 sclk_out = 1'b0;
      end
      #7.5 oe = oe_in;
      cs_n_out = 1'b1;
      #20;
   endtask : frame
endmodule : host_port

// ===== level_sync.sv
module level_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] meta_nxt;
   logic [WIDTH-1:0] sync_r;
   logic [WIDTH-1:0] sync_nxt;

   always_comb begin
      meta_nxt = async_in;
      sync_nxt = meta_r;
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         meta_r <= RST_VAL;
         sync_r <= RST_VAL;
      end else begin
         meta_r <= meta_nxt;
         sync_r <= sync_nxt;
      end
   end

   assign sync_out = sync_r;
endmodule : level_sync

// ===== readout_properties.sv
module readout_chk (
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic sclk_in,
   input wire logic cs_n_in,
   input wire logic result_ready_out,
   input wire logic frame_active_out,
   input wire logic serial_result_out,
   input wire logic serial_result_oe_out
);
   logic [4:0] n;
   always_ff @(posedge sclk_in or posedge cs_n_in) n <= cs_n_in ? 5'h00 : n + 5'h01;
   a_hiz_idle: assert property (
      @(posedge clk_sys_in) disable iff (rst_in) cs_n_in |-> !serial_result_oe_out) else $error("oe idle");
   a_drive_frame: assert property (
      @(negedge sclk_in) disable iff (cs_n_in) n < 5'h11 |-> serial_result_oe_out) else $error("oe low");
   a_hiz_after: assert property (
      @(negedge sclk_in) disable iff (cs_n_in) n > 5'h10 |-> !serial_result_oe_out) else $error("oe late");
   a_tail_zero: assert property (
      @(negedge sclk_in) disable iff (cs_n_in) n == 5'h10 |-> !serial_result_out) else $error("tail bit");
   a_ready_frame: assert property (
      @(posedge clk_sys_in) disable iff (rst_in) frame_active_out |-> ##1 !result_ready_out) else $error("ready");
   a_drive_sys: assert property (
      @(posedge clk_sys_in) disable iff (rst_in) !cs_n_in && n < 5'h11 |-> serial_result_oe_out) else $error("oe lost");
endmodule : readout_chk
bind adc_serial_result_readout readout_chk u_readout_chk (.clk_sys_in, .rst_in, .sclk_in, .cs_n_in,
   .result_ready_out, .frame_active_out, .serial_result_out, .serial_result_oe_out);

// ===== tb_top.sv
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_sys_in = 1'b0, rst_in = 1'b1, result_valid_in = 1'b0, sclk_in, cs_n_in, oe;
   logic result_ready_out, frame_active_out, serial_result_out, serial_result_oe_out;
   logic [15:0] result_in = 16'h0000, got, w;
   logic [15:0] exp_q[$];
   int fail_count = 0, checked = 0, seed = 32'h3e2c, t;
   always #20 clk_sys_in = ~clk_sys_in;
   adc_serial_result_readout u_adc_serial_result_readout (.clk_sys_in, .rst_in, .result_in, .result_valid_in,
      .result_ready_out, .frame_active_out, .sclk_in, .cs_n_in, .serial_result_out, .serial_result_oe_out);
   host_port u_host_port (.sclk_out(sclk_in), .cs_n_out(cs_n_in), .sdo_in(serial_result_out),
      .oe_in(serial_result_oe_out));
   task automatic cmp(input string what, input logic [15:0] e, input logic [15:0] s);
      checked++;
      if (s !== e) begin
         fail_count++;
         $display("[FAIL] %s exp %h seen %h", what, e, s);
      end
   endtask : cmp
   task automatic report_and_stop;
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : report_and_stop
   initial begin
      repeat (20) @(posedge clk_sys_in);
      rst_in <= 1'b0;
      exp_q.push_back(adc_readout_pkg::RESULT_RST);
      for (int k = 0; k < 8; k++) begin
         if (k > 0) begin
            for (t = 0; t < 20 && result_ready_out !== 1'b1; t++) @(negedge clk_sys_in);
            if (t == 20) fail_count++;
            if (t == 20) report_and_stop();
            w = 16'($random(seed));
            @(posedge clk_sys_in);
            result_in <= w;
            result_valid_in <= 1'b1;
            exp_q.push_back(w);
            @(posedge clk_sys_in);
            result_valid_in <= 1'b0;
         end
         repeat (4) @(posedge clk_sys_in);
         u_host_port.frame(16 + k % 2, got, oe);
         cmp("word", exp_q.pop_front(), got);
         cmp("oe end", {15'h0000, k % 2 == 0}, {15'h0000, oe});
         cmp("oe idle", 16'h0000, {15'h0000, serial_result_oe_out});
      end
      report_and_stop();
   end
endmodule : tb_top
